/* File: design/pvs_regs_pkg.sv */
package pvs_regs_pkg;

	// Management frame timing, counted in MDC bits
	localparam int PREAMBLE_BITS = 32;
	localparam int HDR_BITS      = 13;
	localparam int DATA_BITS     = 16;

	// Register addresses
	localparam logic [4:0] ADDR_LOOP_LED   = 5'h11;
	localparam logic [4:0] ADDR_CABLE_DIAG = 5'h12;
	localparam logic [4:0] ADDR_LINK_STAT  = 5'h13;
	localparam logic [4:0] ADDR_SYM_ERR    = 5'h15;
	localparam logic [4:0] ADDR_INT_CS     = 5'h1B;
	localparam logic [4:0] ADDR_PHY_CTRL   = 5'h1F;

	// Frame codes
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;

	// Loopback/LED register layout
	localparam logic [15:0] LOOP_LED_RST  = 16'h02F0;
	localparam logic [15:0] LOOP_LED_MASK = 16'hFFFE;
	localparam int          BIT_REM_LOOP  = 8;
	localparam int          BIT_LED_TEST  = 3;

	// Link status layout
	localparam int BIT_LINK1000 = 2;
	localparam int BIT_LINK100  = 1;

	// Interrupt control/status layout
	localparam int          INT_EN_LSB = 8;
	localparam int          INT_N      = 8;
	localparam logic [7:0]  INT_RST    = 8'h00;

	// PHY control layout
	localparam int BIT_INT_POL = 14;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_HDR  = 5'b00010,
		ST_TA   = 5'b00100,
		ST_RDAT = 5'b01000,
		ST_WDAT = 5'b10000
	} pvs_state_t;

endpackage

/* File: design/pvs_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - Remote loopback bit, reset zero, readable, drives line loopback output.
// - LED test bit, reset zero, places LED outputs in test mode.
// - Read-only gigabit link OK bit, reset zero.
// - Read-only 100 Mb link OK bit, reset zero.
// - 16-bit symbol error frame count, reset zero, cleared when read.
// - Jabber interrupt enable and sticky status, status cleared on read.
// - Receive error interrupt enable and sticky status, cleared on read.
// - Page received interrupt enable and sticky status, cleared on read.
// - Parallel detect fault enable and sticky status, cleared on read.
// - Link partner acknowledge interrupt enable, read/write, reset zero.
// - Link down interrupt enable, read/write, reset zero.
// - Remote fault interrupt enable, read/write, reset zero.
// - Link up interrupt enable, read/write, reset zero.
// - All eight status bits latch their events, cleared when read.
// - Interrupt pin polarity bit, one active high, zero active low.
module pvs_regs
	import pvs_regs_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int         CNT_W    = 16
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              mdc,
	input  wire logic              mdioIn,
	output logic                   mdioOut,
	output logic                   mdioOe,
	input  wire logic              linkOk1000,
	input  wire logic              linkOk100,
	input  wire logic              symErrFrame,
	input  wire logic [INT_N-1:0]  intEvent,
	output logic                   remoteLoopback,
	output logic                   ledTest,
	output logic                   intPin
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic mdcMeta_q, mdcSync_q, mdcPrev_q;
	logic mdioMeta_q, mdioSync_q;
	logic mdcRise, bitIn;
	always_ff @(posedge mclk) begin
		mdcMeta_q  <= mdc;
		mdcSync_q  <= mdcMeta_q;
		mdcPrev_q  <= mdcSync_q;
		mdioMeta_q <= mdioIn;
		mdioSync_q <= mdioMeta_q;
	end
	assign mdcRise = mdcSync_q & ~mdcPrev_q;
	assign bitIn   = mdioSync_q;

	// ************************************************************
	// Register storage and frame engine
	// ************************************************************
	pvs_state_t        state_q, state_d;
	logic [5:0]        preCnt_q, preCnt_d;
	logic [4:0]        bitCnt_q, bitCnt_d;
	logic [11:0]       hdr_q, hdr_d;
	logic              isRead_q, isRead_d;
	logic [4:0]        addr_q, addr_d;
	logic [15:0]       shift_q, shift_d;
	logic              mdioOut_d, mdioOe_d;
	logic [15:0]       loopLed_q, loopLed_d;
	logic              link1000_q, link100_q;
	logic [CNT_W-1:0]  symCnt_q, symCnt_d;
	logic [INT_N-1:0]  intEn_q, intEn_d;
	logic [INT_N-1:0]  intStat_q, intStat_d;
	logic              intPol_q, intPol_d;
	logic              intPin_d;
	logic [12:0]       hdrWord;
	logic [15:0]       wrWord;
	logic              rdFire, wrFire;
	logic              intAct;
	function automatic logic [15:0] readValue(input logic [4:0] a);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			ADDR_LOOP_LED: v = loopLed_q;
			ADDR_LINK_STAT: begin
				v[BIT_LINK1000] = link1000_q;
				v[BIT_LINK100]  = link100_q;
			end
			ADDR_SYM_ERR: v = 16'(symCnt_q);
			ADDR_INT_CS: v = {intEn_q, intStat_q};
			ADDR_PHY_CTRL: v[BIT_INT_POL] = intPol_q;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction
	assign hdrWord = {hdr_q, bitIn};
	assign wrWord  = {shift_q[14:0], bitIn};
	always_comb begin
		state_d   = state_q;
		preCnt_d  = preCnt_q;
		bitCnt_d  = bitCnt_q;
		hdr_d     = hdr_q;
		isRead_d  = isRead_q;
		addr_d    = addr_q;
		shift_d   = shift_q;
		mdioOut_d = mdioOut;
		mdioOe_d  = mdioOe;
		rdFire    = 1'b0;
		wrFire    = 1'b0;
		if (mdcRise) begin
			case (state_q)
				ST_IDLE: begin
					if (bitIn) begin
						if (preCnt_q != 6'(PREAMBLE_BITS))
							preCnt_d = preCnt_q + 6'h01;
					end else if (preCnt_q == 6'(PREAMBLE_BITS)) begin
						state_d  = ST_HDR;
						bitCnt_d = 5'h00;
						preCnt_d = 6'h00;
					end else begin
						preCnt_d = 6'h00;
					end
				end
				ST_HDR: begin
					hdr_d    = hdrWord[11:0];
					bitCnt_d = bitCnt_q + 5'h01;
					if (bitCnt_q == 5'(HDR_BITS - 1)) begin
						bitCnt_d = 5'h00;
						addr_d   = hdrWord[4:0];
						// Frames for another address are skipped whole
						if (!hdrWord[12] || hdrWord[9:5] != PHY_ADDR) begin
							state_d = ST_IDLE;
						end else if (hdrWord[11:10] == OP_READ) begin
							state_d  = ST_TA;
							isRead_d = 1'b1;
							rdFire   = 1'b1;
							shift_d  = readValue(hdrWord[4:0]);
						end else if (hdrWord[11:10] == OP_WRITE) begin
							state_d  = ST_TA;
							isRead_d = 1'b0;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				ST_TA: begin
					bitCnt_d = 5'h01;
					if (bitCnt_q != 5'h00) begin
						bitCnt_d = 5'h00;
						state_d  = isRead_q ? ST_RDAT : ST_WDAT;
						if (isRead_q) begin
							mdioOe_d  = 1'b1;
							mdioOut_d = 1'b0;
						end
					end
				end
				ST_RDAT: begin
					bitCnt_d = bitCnt_q + 5'h01;
					if (bitCnt_q == 5'(DATA_BITS)) begin
						// Release the line one bit after the last data bit
						mdioOe_d = 1'b0;
						state_d  = ST_IDLE;
						bitCnt_d = 5'h00;
					end else begin
						mdioOut_d = shift_q[15];
						shift_d   = {shift_q[14:0], 1'b0};
					end
				end
				ST_WDAT: begin
					shift_d  = wrWord;
					bitCnt_d = bitCnt_q + 5'h01;
					if (bitCnt_q == 5'(DATA_BITS - 1)) begin
						wrFire   = 1'b1;
						state_d  = ST_IDLE;
						bitCnt_d = 5'h00;
					end
				end
				default: begin
					state_d  = ST_IDLE;
					mdioOe_d = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Register side effects
	// ************************************************************
	always_comb begin
		loopLed_d = loopLed_q;
		intEn_d   = intEn_q;
		intPol_d  = intPol_q;
		symCnt_d  = symCnt_q;
		intStat_d = intStat_q;
		if (wrFire) begin
			case (addr_q)
				ADDR_LOOP_LED: loopLed_d = wrWord & LOOP_LED_MASK;
				ADDR_INT_CS: intEn_d = wrWord[INT_EN_LSB +: INT_N];
				ADDR_PHY_CTRL: intPol_d = wrWord[BIT_INT_POL];
				default: intPol_d = intPol_q;
			endcase
		end
		// A read clears first, so an event in the same cycle still counts
		if (rdFire && addr_d == ADDR_SYM_ERR)
			symCnt_d = '0;
		if (symErrFrame && symCnt_d != '1)
			symCnt_d = symCnt_d + CNT_W'(1);
		if (rdFire && addr_d == ADDR_INT_CS)
			intStat_d = INT_RST;
		intStat_d = intStat_d | intEvent;
		intAct    = |(intEn_q & intStat_q);
		intPin_d  = intPol_q ? intAct : ~intAct;
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			preCnt_q   <= 6'h00;
			bitCnt_q   <= 5'h00;
			hdr_q      <= 12'h000;
			isRead_q   <= 1'b0;
			addr_q     <= 5'h00;
			shift_q    <= 16'h0000;
			mdioOut    <= 1'b0;
			mdioOe     <= 1'b0;
			loopLed_q  <= LOOP_LED_RST;
			link1000_q <= 1'b0;
			link100_q  <= 1'b0;
			symCnt_q   <= '0;
			intEn_q    <= INT_RST;
			intStat_q  <= INT_RST;
			intPol_q   <= 1'b0;
			intPin     <= 1'b1;
			remoteLoopback <= 1'b0;
			ledTest    <= 1'b0;
		end else begin
			state_q    <= state_d;
			preCnt_q   <= preCnt_d;
			bitCnt_q   <= bitCnt_d;
			hdr_q      <= hdr_d;
			isRead_q   <= isRead_d;
			addr_q     <= addr_d;
			shift_q    <= shift_d;
			mdioOut    <= mdioOut_d;
			mdioOe     <= mdioOe_d;
			loopLed_q  <= loopLed_d;
			link1000_q <= linkOk1000;
			link100_q  <= linkOk100;
			symCnt_q   <= symCnt_d;
			intEn_q    <= intEn_d;
			intStat_q  <= intStat_d;
			intPol_q   <= intPol_d;
			intPin     <= intPin_d;
			remoteLoopback <= loopLed_d[BIT_REM_LOOP];
			ledTest    <= loopLed_d[BIT_LED_TEST];
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence sWrite(logic [4:0] a);
		wrFire && addr_q == a;
	endsequence
	sequence sReadOf(logic [4:0] a);
		rdFire && addr_d == a;
	endsequence
	AST_LOOPBACK: assert property (sWrite(ADDR_LOOP_LED) |=>
		remoteLoopback == $past(wrWord[BIT_REM_LOOP]))
		else $error("remote loopback not updated by write");
	AST_LEDTEST: assert property (sWrite(ADDR_LOOP_LED) |=>
		ledTest == $past(wrWord[BIT_LED_TEST]))
		else $error("LED test not updated by write");
	AST_LINK1000: assert property (sReadOf(ADDR_LINK_STAT) |=>
		shift_q[BIT_LINK1000] == $past(link1000_q))
		else $error("gigabit link bit read wrong");
	AST_LINK100: assert property (sReadOf(ADDR_LINK_STAT) |=>
		shift_q[BIT_LINK100] == $past(link100_q))
		else $error("fast link bit read wrong");
	AST_CNT_CLEAR: assert property (rdFire && addr_d == ADDR_SYM_ERR
		&& !symErrFrame |=> symCnt_q == '0 ##1 symCnt_q <= CNT_W'(1))
		else $error("symbol error count not cleared on read");
	AST_STAT_SET: assert property (|intEvent |=>
		(intStat_q & $past(intEvent)) == $past(intEvent))
		else $error("event lost from status");
	AST_STAT_CLEAR: assert property (sReadOf(ADDR_INT_CS) |=>
		intStat_q == $past(intEvent))
		else $error("status not cleared on read");
	AST_ENABLES: assert property (sWrite(ADDR_INT_CS) |=>
		intEn_q == $past(wrWord[INT_EN_LSB +: INT_N]))
		else $error("interrupt enables not written");
	AST_INT_PIN: assert property (##1 intPin ==
		($past(intPol_q) ~^ |($past(intEn_q) & $past(intStat_q))))
		else $error("interrupt pin wrong for status and polarity");
	AST_POL_WRITE: assert property (sWrite(ADDR_PHY_CTRL) |=>
		intPol_q == $past(wrWord[BIT_INT_POL]))
		else $error("interrupt polarity not written");
endmodule

/* File: testbench/pvs_mdio_host.sv */
`timescale 1ns/1ps
module pvs_mdio_host
	import pvs_regs_pkg::*;
(
	output logic      mdc,
	output logic      mdioIn,
	input  wire logic mdioOut,
	input  wire logic mdioOe
);
	logic hostOe;
	logic hostBit;

	// Line has a pull-up, so a released line reads one
	assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

	initial begin
		mdc = 1'b0;
		hostOe = 1'b0;
		hostBit = 1'b1;
	end

	// 300 ns period: each half well above the 4 mclk the device needs
	task automatic clk_bit(input logic drv, input logic b, output logic s);
		hostOe = drv;
		hostBit = b;
		#150;
		mdc = 1'b1;
		s = mdioIn;
		#150;
		mdc = 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic [16:0] sh;
		logic        s;
		hdr = {32'hFFFFFFFF, 2'b01, op, phy, ra};
		sh = 17'h00000;
		for (int i = 45; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
		if (op == OP_READ) begin
			// Released for turnaround; first driven sample is the zero
			for (int i = 0; i < 19; i++) begin
				clk_bit(1'b0, 1'b1, s);
				sh = {sh[15:0], s};
			end
		end else begin
			clk_bit(1'b1, 1'b1, s);
			clk_bit(1'b1, 1'b0, s);
			for (int i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
		end
		hostOe = 1'b0;
		rd = sh[15:0];
	endtask
endmodule

/* File: testbench/tb_pvs_regs.sv */
`timescale 1ns/1ps
module tb_pvs_regs;
	import pvs_regs_pkg::*;
	localparam logic [4:0] PHY = 5'h05;
	logic             mclk, rst, mdc, mdioIn, mdioOut, mdioOe;
	logic             linkOk1000, linkOk100, symErrFrame;
	logic             remoteLoopback, ledTest, intPin;
	logic [INT_N-1:0] intEvent;
	logic [15:0]      rd, v;
	logic [7:0]       en;
	int               miscompares, comparisons, n;

	pvs_regs #(.PHY_ADDR(PHY), .CNT_W(16)) i_pvs_regs (.mclk(mclk),
		.rst(rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
		.mdioOe(mdioOe), .linkOk1000(linkOk1000), .linkOk100(linkOk100),
		.symErrFrame(symErrFrame), .intEvent(intEvent),
		.remoteLoopback(remoteLoopback), .ledTest(ledTest), .intPin(intPin));
	pvs_mdio_host i_pvs_mdio_host (.mdc(mdc), .mdioIn(mdioIn),
		.mdioOut(mdioOut), .mdioOe(mdioOe));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	function automatic logic [15:0] b16(input logic b);
		return {15'h0000, b};
	endfunction

	function automatic logic pin_lvl(input logic pol, input logic act);
		return pol ? act : !act;
	endfunction

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask

	task automatic rdr(input logic [4:0] ra);
		i_pvs_mdio_host.frame(OP_READ, PHY, ra, 16'h0000, rd);
	endtask

	task automatic wrr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		i_pvs_mdio_host.frame(OP_WRITE, PHY, ra, d, x);
		tick(6);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#2_000_000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{linkOk1000, linkOk100, symErrFrame} = 3'h0;
		intEvent = 8'h00;
		miscompares = 0;
		comparisons = 0;
		void'($urandom(67538));
		tick(5);
		rst = 1'b0;
		tick(3);
		chk("loopback pin", 16'h0000, b16(remoteLoopback));
		chk("led pin", 16'h0000, b16(ledTest));
		chk("int pin", 16'h0001, b16(intPin));
		rdr(ADDR_LOOP_LED);
		chk("loop_led", LOOP_LED_RST, rd);
		rdr(ADDR_LINK_STAT);
		chk("link", 16'h0000, rd);
		rdr(ADDR_SYM_ERR);
		chk("count", 16'h0000, rd);
		rdr(ADDR_INT_CS);
		chk("int_cs", 16'h0000, rd);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
			wrr(ADDR_LOOP_LED, v);
			chk("loopback pin", b16(v[BIT_REM_LOOP]), b16(remoteLoopback));
			chk("led pin", b16(v[BIT_LED_TEST]), b16(ledTest));
			rdr(ADDR_LOOP_LED);
			chk("loop_led", v & LOOP_LED_MASK, rd);
		end
		// Frames to another address or with a bad opcode are ignored
		i_pvs_mdio_host.frame(OP_WRITE, PHY ^ 5'h01, ADDR_LOOP_LED, ~v, rd);
		i_pvs_mdio_host.frame(2'h3, PHY, ADDR_LOOP_LED, ~v, rd);
		wrr(ADDR_CABLE_DIAG, 16'hFFFF);
		rdr(ADDR_LOOP_LED);
		chk("loop_led kept", v & LOOP_LED_MASK, rd);
		rdr(ADDR_CABLE_DIAG);
		chk("diag", 16'h0000, rd);
		$display("test loopback and led done");
		for (int k = 0; k < 4; k++) begin
			{linkOk1000, linkOk100} = 2'(k);
			tick(3);
			rdr(ADDR_LINK_STAT);
			chk("link", {13'h0000, 2'(k), 1'b0}, rd);
		end
		$display("test link done");
		for (int k = 0; k < 2; k++) begin
			n = (k == 0) ? 1 : 2 + $urandom_range(40);
			repeat (n) begin
				symErrFrame = 1'b1;
				tick(1);
				symErrFrame = 1'b0;
				tick(1 + $urandom_range(3));
			end
			rdr(ADDR_SYM_ERR);
			chk("count", 16'(n), rd);
			rdr(ADDR_SYM_ERR);
			chk("count cleared", 16'h0000, rd);
		end
		$display("test count done");
		for (int p = 0; p < 2; p++) begin
			en = (p == 0) ? 8'h5A : 8'hA5;
			wrr(ADDR_PHY_CTRL, 16'(p) << BIT_INT_POL);
			wrr(ADDR_INT_CS, {en, 8'h00});
			chk("int pin idle", b16(pin_lvl(p[0], 1'b0)), b16(intPin));
			for (int i = 0; i < INT_N; i++) begin
				intEvent = 8'h01 << i;
				tick(1);
				intEvent = 8'h00;
				tick(3);
				chk("int pin", b16(pin_lvl(p[0], en[i])), b16(intPin));
				rdr(ADDR_INT_CS);
				chk("int_cs", {en, 8'h01 << i}, rd);
				tick(3);
				chk("int pin off", b16(pin_lvl(p[0], 1'b0)), b16(intPin));
			end
			rdr(ADDR_INT_CS);
			chk("int_cs", {en, 8'h00}, rd);
		end
		$display("test interrupts done");
		// Reset mid-run must bring back the three pins, loop_led, int_cs and polarity reset values
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(3);
		chk("loopback pin", 16'h0000, b16(remoteLoopback));
		chk("led pin", 16'h0000, b16(ledTest));
		chk("int pin", 16'h0001, b16(intPin));
		rdr(ADDR_LOOP_LED);
		chk("loop_led", LOOP_LED_RST, rd);
		rdr(ADDR_INT_CS);
		chk("int_cs", 16'h0000, rd);
		rdr(ADDR_PHY_CTRL);
		chk("polarity", 16'h0000, rd);
		$display("test reset again done");
		report_and_stop();
	end
endmodule
